// >>> nbpr_host.sv
/*
 host controller that drives a nand flash bus for page read and random
 column output; read data pass through a 32-word fifo to the user.
 assumes an asynchronous flash whose ready/busy and io inputs are pins.
*/
// Summary of operation
// - io bus carries commands, addresses, data; x8 uses 7..0, x16 15..0
// - command latch high makes the write a command byte
// - address latch high makes the write an address byte
// - x8 host sends five address cycles, column then row, unused low
// - x16 host drives io 15..8 low in address cycles
// - page read is 00h, address cycles, 30h, then busy
// - host waits for ready before toggling read enable; after E0h it goes to read without sampling ready
// - below 30 ns cycle, host captures data on the next falling edge; here req_edo only shortens read enable high, data is taken before it rises
// - random output is 05h, column cycles, E0h
`timescale 1ns/1ps
`include "nbpr_defines.svh"
module nbpr_host
   import nbpr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   // user request
   input wire logic req_start,
   input wire logic req_random,
   input wire logic req_x16,
   input wire logic req_edo,
   input wire logic [11:0] req_col,
   input wire logic [17:0] req_row,
   input wire logic [11:0] req_len,
   output logic req_busy,
   output logic req_done,
   // read data
   output logic [15:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   // flash pins
   output logic nand_ce_n,
   output logic nand_cle,
   output logic nand_ale,
   output logic nand_we_n,
   output logic nand_re_n,
   output logic nand_wp_n,
   output logic nand_protect_pin,
   output logic [15:0] nand_io_o,
   output logic nand_io_oe_n,
   input wire logic [15:0] nand_io_i,
   input wire logic nand_rb_n
);
   localparam logic [3:0] STROBE = 4'(`NBPR_STROBE_CYC);
   typedef struct packed {
      nbpr_state_t st;
      logic [2:0] idx;
      logic [3:0] tim;
      logic ph;
      logic rnd;
      logic x16;
      logic edo;
      logic [11:0] col;
      logic [17:0] row;
      logic [11:0] left;
      logic [15:0] cap;
      logic cap_v;
      logic seen_busy;
      logic done;
      logic busy;
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic [15:0] io;
      logic oe_n;
   } nbpr_host_state_t;
   nbpr_host_state_t s_reg;
   nbpr_host_state_t s_next;
   logic [15:0] io_m_reg;
   logic [15:0] io_s_reg;
   logic rb_m_reg;
   logic rb_s_reg;
   nbpr_fifo_if fq ();
   nbpr_fifo #(.WIDTH(16), .DEPTH(`NBPR_FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .wr(fq.dst),
      .rd_data(rd_data),
      .rd_valid(rd_valid),
      .rd_ready(rd_ready)
   );
   assign fq.data = s_reg.cap;
   assign fq.valid = s_reg.cap_v;
   // pins from the flash pass two flops before use
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         io_m_reg <= 16'h0000;
         io_s_reg <= 16'h0000;
         rb_m_reg <= 1'b0;
         rb_s_reg <= 1'b0;
      end
      else if (ce)
      begin
         io_m_reg <= nand_io_i;
         io_s_reg <= io_m_reg;
         rb_m_reg <= nand_rb_n;
         rb_s_reg <= rb_m_reg;
      end
   end
   // byte placed on io for address cycle i
   function automatic logic [15:0] addr_byte(input logic [2:0] i,
      input logic [11:0] c, input logic [17:0] r, input logic w16);
      logic [15:0] b;
      b = 16'h0000;
      unique case (i)
         3'd0: b[7:0] = c[7:0];
         3'd1: b[7:0] = w16 ? {5'h00, c[10:8]} : {4'h0, c[11:8]};
         3'd2: b[7:0] = r[7:0];
         3'd3: b[7:0] = r[15:8];
         default: b[7:0] = {6'h00, r[17:16]};
      endcase
      return b;
   endfunction : addr_byte
   always_comb
   begin
      s_next = s_reg;
      s_next.cap_v = 1'b0;
      s_next.done = 1'b0;
      if (s_reg.tim != 4'h0)
      begin
         s_next.tim = s_reg.tim - 4'h1;
      end
      unique case (s_reg.st)
         ST_IDLE:
         begin
            s_next.ce_n = 1'b1;
            s_next.oe_n = 1'b1;
            if (req_start && req_len != 12'h000)
            begin
               s_next.rnd = req_random;
               s_next.x16 = req_x16;
               s_next.edo = req_edo;
               s_next.col = req_col;
               s_next.row = req_row;
               s_next.left = req_len;
               s_next.ce_n = 1'b0;
               s_next.st = ST_CMD;
               s_next.ph = 1'b0;
               s_next.tim = STROBE;
            end
         end
         ST_CMD, ST_ADDR, ST_CONF:
         begin
            if (s_reg.tim == 4'h0)
            begin
               if (!s_reg.ph)
               begin
                  s_next.oe_n = 1'b0;
                  s_next.we_n = 1'b0;
                  s_next.cle = (s_reg.st != ST_ADDR);
                  s_next.ale = (s_reg.st == ST_ADDR);
                  unique case (s_reg.st)
                     ST_CMD: s_next.io = {8'h00, s_reg.rnd ?
                        `NBPR_CMD_COL : `NBPR_CMD_READ};
                     ST_CONF: s_next.io = {8'h00, s_reg.rnd ?
                        `NBPR_CMD_COL_GO : `NBPR_CMD_READ_GO};
                     default: s_next.io = addr_byte(s_reg.idx, s_reg.col,
                        s_reg.row, s_reg.x16);
                  endcase
                  s_next.ph = 1'b1;
                  s_next.tim = STROBE;
               end
               else
               begin
                  s_next.we_n = 1'b1;
                  s_next.ph = 1'b0;
                  s_next.tim = STROBE;
                  if (s_reg.st == ST_CMD)
                  begin
                     s_next.st = ST_ADDR;
                     s_next.idx = 3'd0;
                  end
                  else if (s_reg.st == ST_ADDR)
                  begin
                     s_next.idx = s_reg.idx + 3'd1;
                     if (s_reg.idx == (s_reg.rnd ? `NBPR_COL_CYCLES :
                         `NBPR_ADDR_CYCLES) - 3'd1)
                     begin
                        s_next.st = ST_CONF;
                     end
                  end
                  else
                  begin
                     s_next.st = s_reg.rnd ? ST_READ : ST_BUSY;
                     s_next.seen_busy = 1'b0;
                  end
               end
            end
            else if (s_reg.ph == 1'b0 && s_reg.tim == 4'h1)
            begin
               s_next.cle = 1'b0;
               s_next.ale = 1'b0;
            end
         end
         ST_BUSY:
         begin
            s_next.oe_n = 1'b1;
            s_next.cle = 1'b0;
            // chip enable stays low; a blip would not abort anyway
            if (!rb_s_reg)
            begin
               s_next.seen_busy = 1'b1;
            end
            if (s_reg.seen_busy && rb_s_reg && s_reg.tim == 4'h0)
            begin
               s_next.st = ST_READ;
               s_next.ph = 1'b0;
            end
         end
         ST_READ:
         begin
            s_next.oe_n = 1'b1;
            s_next.cle = 1'b0;
            if (s_reg.tim == 4'h0 && fq.ready)
            begin
               if (!s_reg.ph)
               begin
                  s_next.re_n = 1'b0;
                  s_next.ph = 1'b1;
                  s_next.tim = STROBE;
               end
               else
               begin
                  // edo shortens the wait past the rising edge to two cycles; stretch adds sync delay
                  s_next.cap = io_s_reg;
                  s_next.cap_v = 1'b1;
                  s_next.re_n = 1'b1;
                  s_next.ph = 1'b0;
                  s_next.tim = s_reg.edo ? 4'h1 : STROBE;
                  s_next.left = s_reg.left - 12'h001;
                  if (s_reg.left == 12'h001)
                  begin
                     s_next.st = ST_DONE;
                  end
               end
            end
         end
         default:
         begin
            s_next.ce_n = 1'b1;
            s_next.done = 1'b1;
            s_next.st = ST_IDLE;
         end
      endcase
      // registered so the user sees busy straight from a flop
      s_next.busy = (s_next.st != ST_IDLE);
   end
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_reg <= '{st: ST_IDLE, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1,
                    oe_n: 1'b1, default: '0};
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end
   // outputs straight from flops
   assign nand_ce_n = s_reg.ce_n;
   assign nand_cle = s_reg.cle;
   assign nand_ale = s_reg.ale;
   assign nand_we_n = s_reg.we_n;
   assign nand_re_n = s_reg.re_n;
   assign nand_io_o = s_reg.io;
   assign nand_io_oe_n = s_reg.oe_n;
   assign req_done = s_reg.done;
   assign req_busy = s_reg.busy;
   // read-only host keeps the array protected
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         nand_wp_n <= 1'b0;
         nand_protect_pin <= 1'b0;
      end
      else
      begin
         nand_wp_n <= 1'b0;
         nand_protect_pin <= 1'b0;
      end
   end
endmodule : nbpr_host

// >>> nbpr_defines.svh
/*
 constants for the host-side nand page read controller: commands, timing
 counts and geometry. assumes clk_sys at 100 MHz.
*/
`ifndef NBPR_DEFINES_SVH
`define NBPR_DEFINES_SVH
`define NBPR_CLK_NS 10
`define NBPR_CMD_READ 8'h00
`define NBPR_CMD_READ_GO 8'h30
`define NBPR_CMD_COL 8'h05
`define NBPR_CMD_COL_GO 8'he0
`define NBPR_PAGE_BYTES 12'd2112
`define NBPR_PAGE_WORDS 12'd1056
`define NBPR_MAIN_BYTES 12'd2048
`define NBPR_SPARE_BYTES 12'd64
`define NBPR_PAGES_PER_BLK 7'd64
`define NBPR_ADDR_CYCLES 3'd5
`define NBPR_COL_CYCLES 3'd2
`define NBPR_EDO_LIMIT_NS 30
`define NBPR_STROBE_NS 30
`define NBPR_STROBE_CYC ((`NBPR_STROBE_NS + `NBPR_CLK_NS - 1) / `NBPR_CLK_NS)
`define NBPR_FIFO_DEPTH 32
`endif

// >>> nbpr_pkg.sv
/*
 types for the nand page read controller. assumes nbpr_defines.svh.
*/
package nbpr_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_CMD = 4'h1,
      ST_ADDR = 4'h2,
      ST_CONF = 4'h3,
      ST_BUSY = 4'h4,
      ST_READ = 4'h5,
      ST_DONE = 4'h6
   } nbpr_state_t;
endpackage : nbpr_pkg

// >>> nbpr_fifo_if.sv
/*
 interface carrying a valid/ready word stream between modules.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface nbpr_fifo_if;
   logic [15:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport dst (input data, input valid, output ready);
endinterface : nbpr_fifo_if

// >>> nbpr_fifo.sv
/*
 synchronous fifo, width and depth parameters, read data from a register.
 assumes a single clock and power-of-two depth.
*/
`timescale 1ns/1ps
module nbpr_fifo
   import nbpr_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
)
(
   // clock
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   // fill side
   nbpr_fifo_if.dst wr,
   // drain side
   output logic [WIDTH-1:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_reg;
   logic [AW:0] rp_reg;
   logic full;
   logic empty;
   logic do_wr;
   logic do_rd;
   assign full = (wp_reg[AW] != rp_reg[AW]) &&
                 (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
   assign empty = (wp_reg == rp_reg);
   assign wr.ready = !full;
   // output register counts as one slot of look-ahead
   assign do_rd = !empty && (!rd_valid || rd_ready);
   assign do_wr = wr.valid && !full;
   always_ff @(posedge clk_sys)
   begin
      if (ce && do_wr)
      begin
         mem[wp_reg[AW-1:0]] <= wr.data;
      end
   end
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wp_reg <= '0;
         rp_reg <= '0;
         rd_data <= '0;
         rd_valid <= 1'b0;
      end
      else if (ce)
      begin
         if (do_wr)
         begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (do_rd)
         begin
            rp_reg <= rp_reg + 1'b1;
            rd_data <= mem[rp_reg[AW-1:0]];
            rd_valid <= 1'b1;
         end
         else if (rd_ready)
         begin
            rd_valid <= 1'b0;
         end
      end
   end
endmodule : nbpr_fifo

// >>> nbpr_monitor.sv
/*
 assertions on the page read host pins.
 assumes one clk_sys domain; bound to nbpr_host below.
*/
`timescale 1ns/1ps
module nbpr_monitor
(
   // clock
   input wire logic clk_sys,
   input wire logic rstn,
   // user
   input wire logic req_x16,
   // flash
   input wire logic nand_ce_n,
   input wire logic nand_cle,
   input wire logic nand_ale,
   input wire logic nand_we_n,
   input wire logic nand_re_n,
   input wire logic nand_wp_n,
   input wire logic nand_protect_pin,
   input wire logic [15:0] nand_io_o,
   input wire logic nand_io_oe_n,
   input wire logic nand_rb_n
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   chk_latch_apart: assert property (
      !(nand_cle && nand_ale)) else $error("cle with ale");
   chk_write_drives: assert property (
      !nand_we_n |-> !nand_io_oe_n && !nand_ce_n && (nand_cle || nand_ale))
      else $error("write strobe undriven");
   chk_strobe_width: assert property (
      $fell(nand_we_n) |-> !nand_we_n [*4] ##1 nand_we_n)
      else $error("write strobe width");
   chk_byte_steady: assert property (
      !nand_we_n |=> nand_we_n || $stable({nand_io_o, nand_cle, nand_ale}))
      else $error("bus moved in strobe");
   chk_read_bus_free: assert property (
      !nand_re_n |-> nand_io_oe_n && !nand_ce_n && nand_we_n)
      else $error("read with bus driven");
   chk_read_ready: assert property (
      $fell(nand_re_n) |-> $past(nand_rb_n, 2) && $past(nand_rb_n, 3))
      else $error("read while busy");
   chk_protect_low: assert property (
      !nand_wp_n && !nand_protect_pin) else $error("protect pins high");
   chk_wide_upper: assert property (
      req_x16 && nand_ale && !nand_we_n |-> nand_io_o[15:8] == 8'h00)
      else $error("upper byte in address");
endmodule : nbpr_monitor
bind nbpr_host nbpr_monitor mon_u (.clk_sys, .rstn, .req_x16, .nand_ce_n,
   .nand_cle, .nand_ale, .nand_we_n, .nand_re_n, .nand_wp_n,
   .nand_protect_pin, .nand_io_o, .nand_io_oe_n, .nand_rb_n);

// >>> nbpr_flash_model.sv
/*
 behavioural nand device: commands, address cycles, busy and read-out.
 assumes a pull-up on ready/busy.
*/
`timescale 1ns/1ps
module nbpr_flash_model
#(
   parameter int TR_NS = 1000,
   parameter int REA_NS = 8
)
(
   // width strap
   input wire logic x16,
   // control
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic wp_n,
   input wire logic protect_pin,
   // data and status
   input wire logic [15:0] io_in,
   output logic [15:0] io_out = 16'h0000,
   output logic rb_n = 1'b1
);
   logic [7:0] ab [5];
   logic [2:0] n = 3'h0;
   logic [11:0] col = 12'h000;
   logic [23:0] row;
   wire logic [11:0] acol = {x16 ? 1'b0 : ab[1][3], ab[1][2:0], ab[0]};
   // read-only: program and erase are always refused
   always @(posedge we_n)
      if (!ce_n && rb_n)
      begin
         if (cle && io_in[7:0] == 8'h30)
         begin
            row = {ab[4], ab[3], ab[2]};
            col = acol;
            rb_n = 1'b0;
            rb_n <= #TR_NS 1'b1; // ce ignored while busy
         end
         else if (cle && io_in[7:0] == 8'he0)
            col = acol;
         else if (cle)
            n = 3'h0;
         else if (ale && n < 3'h5)
         begin
            ab[n] = io_in[7:0];
            n = n + 3'h1;
         end
      end
   always @(negedge re_n)
      if (!ce_n && rb_n)
      begin
         io_out <= #REA_NS {col[11:4] ^ row[7:0], col[7:0] ^ row[15:8]};
         col = col + 12'h001;
      end
   // released bus holds the data 15 ns after the rising edge, then shows the inverse
   always @(posedge re_n)
      io_out <= #15 ~io_out;
   always @(posedge ce_n) // standby only when ready
      if (rb_n)
         io_out <= ~io_out;
endmodule : nbpr_flash_model

// >>> nbpr_host_tb.sv
/*
 self-checking bench for the page read host with a flash model.
 assumes the checker binds itself to the host.
*/
`timescale 1ns/1ps
module nbpr_host_tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic req_start = 1'b0;
   logic req_random = 1'b0;
   logic req_x16 = 1'b0;
   logic req_edo = 1'b0;
   logic [11:0] req_col = 12'h000;
   logic [17:0] req_row = 18'h00000;
   logic [11:0] req_len = 12'h000;
   logic rd_ready = 1'b0;
   logic req_busy, req_done, rd_valid;
   logic [15:0] rd_data, io_o, io_fl;
   logic ce_n, cle, ale, we_n, re_n, wp_n, pt, oe_n, rb_n;
   wire logic [15:0] io_bus = oe_n ? io_fl : io_o;
   int errors = 0;
   int compares = 0;
   always #5 clk_sys = ~clk_sys;
   nbpr_host dut_u (.clk_sys, .rstn, .ce, .req_start, .req_random,
      .req_x16, .req_edo, .req_col, .req_row, .req_len, .req_busy,
      .req_done, .rd_data, .rd_valid, .rd_ready, .nand_ce_n(ce_n),
      .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n),
      .nand_wp_n(wp_n), .nand_protect_pin(pt), .nand_io_o(io_o),
      .nand_io_oe_n(oe_n), .nand_io_i(io_bus), .nand_rb_n(rb_n));
   nbpr_flash_model #(.TR_NS(1000), .REA_NS(8)) flash_u (.x16(req_x16),
      .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .protect_pin(pt),
      .io_in(io_bus), .io_out(io_fl), .rb_n);
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want)
      begin
         errors++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   // hold > 0 stalls the read side that many cycles, then 40 more with ce low
   task automatic run(input logic rnd, w16, edo, input logic [11:0] c,
      input logic [17:0] r, input logic [11:0] n, input int hold);
      logic [15:0] e;
      logic [11:0] cc;
      logic dn;
      int got;
      dn = 1'b0;
      got = 0;
      @(posedge clk_sys);
      #1;
      {req_random, req_x16, req_edo, req_col, req_row} = {rnd, w16, edo, c, r};
      req_len = n;
      req_start = 1'b1;
      // drain side stalled until the scenario lets it go
      rd_ready = 1'b0;
      @(posedge clk_sys);
      #1;
      req_start = 1'b0;
      if (hold > 0)
      begin
         repeat (hold) @(posedge clk_sys);
         #1;
         check({14'h0, rd_valid, req_busy}, 16'h0003);
         ce = 1'b0;
         repeat (40) @(posedge clk_sys);
         #1;
         ce = 1'b1;
      end
      rd_ready = 1'b1;
      // word on show is judged before the edge that takes it
      for (int k = 0; k < 20000 && !(dn && got == int'(n)); k++)
      begin
         dn = dn | (req_done === 1'b1);
         if (rd_valid === 1'b1)
         begin
            cc = c + got[11:0];
            e = {cc[11:4] ^ r[7:0], cc[7:0] ^ r[15:8]};
            if (!w16)
               e[15:8] = 8'h00;
            check(w16 ? rd_data : {8'h00, rd_data[7:0]}, e);
            got++;
         end
         @(posedge clk_sys);
         #1;
         req_start = (k == 10); // ignored while busy
      end
      check(16'(got), {4'h0, n});
      check({15'h0, dn}, 16'h0001);
      repeat (3) @(posedge clk_sys);
      #1;
      check({15'h0, req_busy}, 16'h0000);
   endtask : run
   task automatic s_reset;
      check({11'h0, ce_n, wp_n, pt, req_busy, rd_valid}, 16'h0010);
   endtask : s_reset
   task automatic s_tail_x8;
      run(0, 0, 0, 12'd2108, 18'h2a5c3, 12'd4, 0);
   endtask : s_tail_x8
   task automatic s_rand_x8;
      run(1, 0, 1, 12'd2046, 18'h2a5c3, 12'd3, 0);
   endtask : s_rand_x8
   task automatic s_x16_edo;
      run(0, 1, 1, 12'd1053, 18'h1f0e1, 12'd3, 0);
   endtask : s_x16_edo
   task automatic s_fill;
      run(0, 0, 0, 12'h010, 18'h00155, 12'd40, 1500);
   endtask : s_fill
   task automatic test_done;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (15) @(posedge clk_sys);
      #1;
      s_reset;
      @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      s_tail_x8;
      s_rand_x8;
      s_x16_edo;
      s_fill;
      test_done;
   end
   initial
   begin
      #300000;
      errors++;
      test_done;
   end
endmodule : nbpr_host_tb
